// *** afsr_pkg.sv ***
// afsr_pkg: constants and carriers for the sample fifo status and readout block.
// assumes the i/o decoder ahead of it already runs on sys_clk_i.
package afsr_pkg;
    // -------------------------------------------------------------
    // i/o offsets
    // -------------------------------------------------------------
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_CHAN = 4'h2;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
    localparam logic [3:0] OFS_STAT_HI = 4'ha;
    localparam logic [3:0] OFS_STAT_LO = 4'hf;
    // -------------------------------------------------------------
    // sizes and thresholds
    // -------------------------------------------------------------
    localparam int MAIN_DEPTH = 1024;
    localparam int MAIN_CW = 11;
    localparam int FRAG_DEPTH = 8;
    localparam int FRAG_CW = 4;
    localparam int SAMPLE_W = 16;
    localparam int BLK_SHIFT = 8;
    localparam int BLK_W = 12;
    localparam logic [11:0] LEGACY_BLOCKS = 12'h002;
    localparam logic [11:0] BLOCKS_RESET = 12'h000;
    localparam logic [15:0] MASK_BLOCKS = 16'h0fff;
    localparam logic [15:0] MASK_EMPTY = 16'h1000;
    localparam logic [15:0] MASK_FULL = 16'h2000;
    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic rd;
        logic wr;
        logic [SAMPLE_W-1:0] wdata;
    } afsr_io_req_s;

    typedef struct packed {
        logic level_irq;
        logic fragment_ready_flag;
        logic fifo_full_flag;
        logic fifo_empty_flag;
        logic [BLK_W-1:0] blocks;
    } afsr_status_s;
endpackage

// *** afsr_top.sv ***
// afsr_top: sample fifo, fragment buffer, fifo_level_flags readout and level flag.
// assumes i/o strobes are one-cycle pulses from a decoder on sys_clk_i and that
// the host waits while io_ready_o is low.
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------
// small flip-flop fifo, used for the main store and the fragment
// -------------------------------------------------------------
module afsr_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    input wire logic sys_clk_i, // system clock
    input wire logic reset_i, // sync reset, high
    input wire logic clr_i, // flush contents
    input wire logic push_i, // write one entry
    input wire logic [W-1:0] push_data_i, // entry to write
    input wire logic pop_i, // drop head entry
    output logic [W-1:0] head_o, // head entry
    output logic [CW-1:0] count_o, // entries held
    output logic full_o, // no room
    output logic empty_o // nothing held
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [CW-1:0] count_reg;
    wire logic do_push = push_i && !full_o;
    wire logic do_pop = pop_i && !empty_o;

    assign full_o = (count_reg == CW'(DEPTH));
    assign empty_o = (count_reg == '0);
    assign count_o = count_reg;
    assign head_o = mem_reg[rptr_reg];

    always_ff @(posedge sys_clk_i) begin
        if (do_push) begin
            mem_reg[wptr_reg] <= push_data_i;
        end
    end

    // pointers wrap by power-of-two depth, so order is kept
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || clr_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wptr_reg <= wptr_reg + AW'(do_push);
            rptr_reg <= rptr_reg + AW'(do_pop);
            count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule

// -------------------------------------------------------------
// top
// -------------------------------------------------------------
module afsr_top (
    input wire logic sys_clk_i, // 200 mhz system clock
    input wire logic reset_i, // sync reset, high
    input wire afsr_pkg::afsr_io_req_s io_req_i, // decoded i/o request
    output logic [15:0] io_rdata_o, // read data, registered
    output logic io_rdata_oe_o, // read data driven, registered
    output logic io_rack_o, // read answered, one-cycle pulse
    output logic io_ready_o, // low while a wait state is inserted
    input wire logic sample_valid_i, // sample from the sampling engine
    input wire logic [15:0] sample_data_i, // sample value
    input wire logic superset_jumper_i, // jumper pin, asynchronous
    input wire logic [1:0] irq_block_select_i, // level threshold select
    input wire logic threshold_reg_en_i, // use threshold register instead
    input wire logic [11:0] irq_threshold_i, // threshold in blocks
    output logic level_irq_o, // fifo level flag, registered
    output afsr_pkg::afsr_status_s status_o // live status word
);
    // -------------------------------------------------------------
    // jumper synchroniser
    // -------------------------------------------------------------
    logic jmp_meta_reg;
    logic jmp_reg;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            jmp_meta_reg <= 1'b0;
            jmp_reg <= 1'b0;
        end else begin
            jmp_meta_reg <= superset_jumper_i;
            jmp_reg <= jmp_meta_reg;
        end
    end

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    wire logic rd_data = io_req_i.rd && (io_req_i.addr == afsr_pkg::OFS_DATA);
    wire logic rd_hi = io_req_i.rd && (io_req_i.addr == afsr_pkg::OFS_STAT_HI);
    wire logic rd_lo = io_req_i.rd && (io_req_i.addr == afsr_pkg::OFS_STAT_LO);
    wire logic fifo_clr = io_req_i.wr && (io_req_i.addr == afsr_pkg::OFS_CHAN);
    wire logic irq_clr = io_req_i.wr && (io_req_i.addr == afsr_pkg::OFS_IRQ_CLR);

    // -------------------------------------------------------------
    // main store feeding the fragment buffer
    // -------------------------------------------------------------
    logic [15:0] main_head;
    logic [afsr_pkg::MAIN_CW-1:0] main_cnt;
    logic main_full;
    logic main_empty;
    logic [15:0] frag_head;
    logic [afsr_pkg::FRAG_CW-1:0] frag_cnt;
    logic frag_full;
    logic frag_empty;
    logic pend_reg;

    // fragment refills one sample a cycle, so a read burst cannot drain it faster than it refills
    wire logic xfer = !main_empty && !frag_full;
    wire logic serve_now = rd_data && !frag_empty && !pend_reg;
    wire logic serve_late = pend_reg && !frag_empty;
    wire logic frag_pop = serve_now || serve_late;
    wire logic wait_start = rd_data && frag_empty && !main_empty && !pend_reg;
    wire logic overflow = sample_valid_i && main_full;

    afsr_fifo #(
        .W(afsr_pkg::SAMPLE_W),
        .DEPTH(afsr_pkg::MAIN_DEPTH),
        .CW(afsr_pkg::MAIN_CW)
    ) u_main (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clr_i(fifo_clr),
        .push_i(sample_valid_i),
        .push_data_i(sample_data_i),
        .pop_i(xfer),
        .head_o(main_head),
        .count_o(main_cnt),
        .full_o(main_full),
        .empty_o(main_empty)
    );

    afsr_fifo #(
        .W(afsr_pkg::SAMPLE_W),
        .DEPTH(afsr_pkg::FRAG_DEPTH),
        .CW(afsr_pkg::FRAG_CW)
    ) u_frag (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .clr_i(fifo_clr),
        .push_i(xfer),
        .push_data_i(main_head),
        .pop_i(frag_pop),
        .head_o(frag_head),
        .count_o(frag_cnt),
        .full_o(frag_full),
        .empty_o(frag_empty)
    );

    // -------------------------------------------------------------
    // status word
    // -------------------------------------------------------------
    logic full_reg;
    logic irq_reg;
    wire logic [11:0] total = 12'(main_cnt) + 12'(frag_cnt);
    wire logic [11:0] blocks = total >> afsr_pkg::BLK_SHIFT;
    wire logic [11:0] thr_blocks = threshold_reg_en_i ? irq_threshold_i
        : 12'(afsr_pkg::LEGACY_BLOCKS << irq_block_select_i);
    // a zero threshold would hold the flag forever, so it fires on any sample instead
    wire logic irq_hit = (blocks >= thr_blocks) && (total != 12'h000);

    assign status_o.level_irq = irq_reg;
    assign status_o.fragment_ready_flag = !frag_empty;
    assign status_o.fifo_full_flag = full_reg;
    assign status_o.fifo_empty_flag = (total == 12'h000);
    assign status_o.blocks = blocks;
    assign level_irq_o = irq_reg;

    // sticky until the channel write; a sample arriving with the clear is dropped
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || fifo_clr) begin
            full_reg <= 1'b0;
        end else if (main_full || overflow) begin
            full_reg <= 1'b1;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
        end else if (irq_hit) begin
            irq_reg <= 1'b1;
        end else if (irq_clr) begin
            irq_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // read answer
    // -------------------------------------------------------------
    wire logic [15:0] stat_word = status_o;
    wire logic stat_rd = (rd_hi || rd_lo) && jmp_reg;
    wire logic [15:0] data_word = serve_late ? frag_head : (serve_now ? frag_head : 16'h0000);
    wire logic [15:0] stat_byte = rd_hi ? {8'h00, stat_word[15:8]} : {8'h00, stat_word[7:0]};
    wire logic ack_next = serve_late || (rd_data && !wait_start && !pend_reg) || stat_rd;
    wire logic [15:0] rdata_next = stat_rd ? stat_byte : data_word;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pend_reg <= 1'b0;
            io_rack_o <= 1'b0;
            io_rdata_oe_o <= 1'b0;
            io_rdata_o <= 16'h0000;
        end else begin
            pend_reg <= wait_start || (pend_reg && frag_empty);
            io_rack_o <= ack_next;
            io_rdata_oe_o <= ack_next;
            io_rdata_o <= ack_next ? rdata_next : 16'h0000;
        end
    end

    assign io_ready_o = !pend_reg;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_reset_values: assert property (@(posedge sys_clk_i)
        $past(reset_i) |-> (blocks == afsr_pkg::BLOCKS_RESET) && status_o.fifo_empty_flag
            && !full_reg && !irq_reg)
        else $error("status not at reset values");
    a_empty_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        status_o.fifo_empty_flag == (main_empty && frag_empty))
        else $error("empty flag disagrees with contents");
    a_full_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (main_full && !fifo_clr) |=> full_reg)
        else $error("full flag missed a full fifo");
    a_partial_block: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (blocks == 12'h000 && !status_o.fifo_empty_flag) |-> (total < 12'h100))
        else $error("zero blocks but a whole block held");
    a_clear_empties: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        fifo_clr |=> status_o.fifo_empty_flag && !full_reg)
        else $error("channel write did not clear fifo");
    a_word_layout: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ((stat_word & afsr_pkg::MASK_BLOCKS) == 16'(blocks))
            && (((stat_word & afsr_pkg::MASK_EMPTY) != 0) == (total == 12'h000))
            && (((stat_word & afsr_pkg::MASK_FULL) != 0) == full_reg))
        else $error("status word layout wrong");
    a_irq_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (irq_reg && !irq_clr) |=> irq_reg)
        else $error("level flag dropped without clear");
    a_no_idle_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_data && !frag_empty && !pend_reg) |=> io_ready_o && io_rack_o)
        else $error("wait state with fragment data present");
    a_late_serve: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wait_start |=> !io_ready_o ##[1:4] io_rack_o)
        else $error("pending read not served in time");
    a_stat_gated: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ((rd_hi || rd_lo) && !jmp_reg) |=> !io_rack_o)
        else $error("status answered without jumper");
endmodule

`default_nettype wire

// *** afsr_host_model.sv ***
// afsr_host_model: host cpu side of the i/o bus for afsr_top.
// assumes one request at a time; tasks are called from the testbench.
`timescale 1ns/1ps
`default_nettype none
module afsr_host_model (
    input wire logic sys_clk_i, // system clock
    input wire logic rack_i, // read answered
    input wire logic ready_i, // low while waiting
    output afsr_pkg::afsr_io_req_s req_o // request to the block
);
    initial req_o = '0;
    // ---------------------------------------------
    // one bus cycle; ok is low if no answer in time
    // ---------------------------------------------
    task automatic access(input logic [3:0] a, input logic wr, input logic [15:0] d,
        input int wmax, output bit ok);
        int n;
        ok = 1'b0;
        n = 0;
        // never request while a wait state stands
        while (ready_i !== 1'b1 && n < 8) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        // a wait state still standing after 8 cycles leaves ok low
        if (ready_i !== 1'b1) begin
            return;
        end
        @(posedge sys_clk_i);
        req_o <= '{addr: a, rd: !wr, wr: wr, wdata: d};
        @(posedge sys_clk_i);
        // released address and data lines show the inverse, not the last value; rd and wr go low
        req_o <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
        if (wr) begin
            ok = 1'b1;
            return;
        end
        for (n = 0; n < wmax; n++) begin
            #1;
            if (rack_i === 1'b1) begin
                ok = 1'b1;
                break;
            end
            @(posedge sys_clk_i);
        end
    endtask
endmodule
`default_nettype wire

// *** tb_afsr_top.sv ***
// tb_afsr_top: self-checking bench for afsr_top.
// assumes afsr_pkg and afsr_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_afsr_top;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    afsr_pkg::afsr_io_req_s io_req;
    logic [15:0] rdata;
    logic rdata_oe, rack, ready, level;
    afsr_pkg::afsr_status_s status;
    logic s_valid = 1'b0;
    logic [15:0] s_data = 16'h0000;
    logic jumper = 1'b0;
    logic [1:0] sel = 2'h0;
    logic thr_en = 1'b0;
    logic [11:0] thr = 12'h000;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rng = 32'h000117be;
    logic [15:0] sq[$];
    logic [15:0] eq[$];
    bit ok;
    always #2.5 sys_clk_i = ~sys_clk_i;
    afsr_top afsr_top_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .io_req_i(io_req),
        .io_rdata_o(rdata), .io_rdata_oe_o(rdata_oe), .io_rack_o(rack), .io_ready_o(ready),
        .sample_valid_i(s_valid), .sample_data_i(s_data), .superset_jumper_i(jumper),
        .irq_block_select_i(sel), .threshold_reg_en_i(thr_en), .irq_threshold_i(thr),
        .level_irq_o(level), .status_o(status));
    afsr_host_model afsr_host_model_inst (.sys_clk_i(sys_clk_i), .rack_i(rack),
        .ready_i(ready), .req_o(io_req));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic miss(input string m);
        num_errors++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) miss($sformatf("%s got %h exp %h", m, got, exp));
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic [3:0] a, input logic wr, input bit exp_ok);
        afsr_host_model_inst.access(a, wr, 16'h0000, 4, ok);
        cmp_count++;
        if (ok != exp_ok) begin
            miss("bus answer");
            tally_and_finish();
        end
    endtask
    task automatic rd_data(input int n);
        repeat (n) begin
            eq.push_back(sq.size() > 0 ? sq.pop_front() : 16'h0000);
            bus(afsr_pkg::OFS_DATA, 1'b0, 1'b1);
        end
    endtask
    task automatic rd_stat(input logic [7:0] hi, input logic [7:0] lo);
        eq.push_back({8'h00, hi});
        bus(afsr_pkg::OFS_STAT_HI, 1'b0, 1'b1);
        eq.push_back({8'h00, lo});
        bus(afsr_pkg::OFS_STAT_LO, 1'b0, 1'b1);
    endtask
    task automatic push(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            rng = xorshift(rng);
            s_valid <= 1'b1;
            s_data <= rng[15:0];
            // total room is main store plus fragment
            if (sq.size() < 1032) sq.push_back(rng[15:0]);
        end
        @(posedge sys_clk_i);
        s_valid <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a);
        bus(a, 1'b1, 1'b1);
        if (a == afsr_pkg::OFS_CHAN) sq.delete();
        idle(2);
    endtask
    // ---------------------------------------------
    // answer watcher
    // ---------------------------------------------
    always @(posedge sys_clk_i) begin
        if (rack === 1'b1) begin
            chk({15'h0000, rdata_oe}, 16'h0001, "oe");
            if (eq.size() == 0) miss("unexpected answer");
            else chk(rdata, eq.pop_front(), "read data");
        end else if (reset_i === 1'b0) begin
            chk(rdata, 16'h0000, "idle data");
            chk({15'h0000, rdata_oe}, 16'h0000, "idle oe");
        end
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        idle(1);
        chk(status, 16'h1000, "reset status");
        chk({14'h0000, level, ready}, 16'h0001, "reset level ready");
        afsr_host_model_inst.access(afsr_pkg::OFS_STAT_HI, 1'b0, 16'h0000, 4, ok);
        chk({15'h0000, ok}, 16'h0000, "status without jumper");
        @(posedge sys_clk_i);
        jumper <= 1'b1;
        idle(3);
        $display("test 1 done");
        push(300);
        idle(3);
        chk(status, 16'h4001, "one block");
        rd_stat(8'h40, 8'h01);
        rd_stat(8'h40, 8'h01);
        rd_data(256);
        idle(3);
        chk(status, 16'h4000, "under one block");
        rd_data(44);
        idle(3);
        chk(status, 16'h1000, "drained");
        rd_data(1);
        // a read taken while the only sample is still on its way to the fragment
        fork
            push(1);
            begin
                @(posedge sys_clk_i);
                #1;
                rd_data(1);
            end
            begin
                repeat (3) @(posedge sys_clk_i);
                #1;
                chk({15'h0000, ready}, 16'h0000, "wait state");
            end
        join
        idle(3);
        chk(status, 16'h1000, "pending read drained");
        $display("test 2 done");
        push(1040);
        idle(3);
        chk(status, 16'he004, "full");
        rd_stat(8'he0, 8'h04);
        wr_reg(afsr_pkg::OFS_IRQ_CLR);
        chk({15'h0000, level}, 16'h0001, "level held");
        wr_reg(afsr_pkg::OFS_CHAN);
        chk(status, 16'h9000, "cleared");
        wr_reg(afsr_pkg::OFS_IRQ_CLR);
        chk(status, 16'h1000, "level cleared");
        $display("test 3 done");
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk_i);
            sel <= (i == 1) ? 2'h1 : 2'h0;
            thr_en <= (i == 2);
            thr <= 12'h003;
            wr_reg(afsr_pkg::OFS_CHAN);
            wr_reg(afsr_pkg::OFS_IRQ_CLR);
            push((i == 0 ? 2 : (i == 1 ? 4 : 3)) * 256 - 1);
            idle(3);
            chk({15'h0000, level}, 16'h0000, "below threshold");
            push(1);
            idle(3);
            chk({15'h0000, level}, 16'h0001, "at threshold");
        end
        @(posedge sys_clk_i);
        sel <= 2'h2;
        thr_en <= 1'b0;
        wr_reg(afsr_pkg::OFS_CHAN);
        wr_reg(afsr_pkg::OFS_IRQ_CLR);
        push(1040);
        idle(3);
        chk({15'h0000, level}, 16'h0000, "threshold beyond capacity");
        chk(status, 16'h6004, "full below threshold");
        $display("test 4 done");
        idle(4);
        chk(16'(eq.size()), 16'h0000, "answers missing");
        tally_and_finish();
    end
endmodule
`default_nettype wire
